// ===== rtl/servo_status_output.sv
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
module servo_status_output import servo_status_pkg::*; #(
   parameter int SPD_W = 16,
   parameter int POS_W = 24,
   parameter int TRQ_W = 16,
   parameter int TICK_DIV = TICK_CYCLES
) (
   // clock and reset
   input wire logic CORE_CLK_IN,
   input wire logic SRST_IN,
   // apb slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // drive conditions
   input wire logic CTRL_POWER_IN,
   input wire logic [SPD_W-1:0] SPEED_IN,
   input wire logic [POS_W-1:0] POS_ERR_IN,
   input wire logic [TRQ_W-1:0] TORQUE_IN,
   input wire logic [TRQ_W-1:0] EXT_TRQ_LIMIT_IN,
   input wire logic FAULT_IN,
   input wire logic [4:0] WARN_COND_IN,
   input wire logic OVERLOAD_IN,
   // status outputs
   output logic TARGET_SPEED_REACHED_OUT,
   output logic POSITION_WINDOW_REACHED_OUT,
   output logic TORQUE_LIMITED_FLAG_OUT,
   output logic FAULT_ALARM_OUT,
   output logic BRAKE_CONTROL_OUT,
   output logic OVERLOAD_WARNING_OUT,
   output logic ZERO_SPEED_FLAG_OUT,
   output logic SERVO_ON_STATE_OUT,
   output logic WARNING_OUT,
   output logic [7:0] ALARM_CODE_OUT,
   output logic [1:0] DO_OUT,
   output logic IRQ_OUT
);

   localparam int TW = $clog2(TICK_DIV + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_DIV - 1);

   typedef struct packed {
      logic [2:0] pwr_sync;
      logic servo_on;
      logic [2:0] mode;
      logic ext_lim;
      logic ol_clear;
      logic [SPD_W-1:0] tgt;
      logic [SPD_W-1:0] zero;
      logic [POS_W-1:0] win;
      logic [TRQ_W-1:0] tlim;
      logic [15:0] bon;
      logic [15:0] boff;
      logic [7:0] pct;
      logic [15:0] perm;
      logic [7:0] sel0;
      logic [7:0] sel1;
      logic [INT_W-1:0] ist;
      logic [INT_W-1:0] imask;
      logic target_speed_reached;
      logic position_window_reached;
      logic torque_limited_flag;
      logic alarm;
      logic brake;
      logic overload_warning_out;
      logic zero_speed_flag;
      logic warn;
      logic [7:0] acode;
      logic [1:0] dout;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [TW-1:0] tick_cnt;
      logic tick;
   } top_s;

   top_s st_reg;
   top_s st_next;
   logic brk_raw;
   logic ol_warn_raw;
   logic ol_alarm_raw;

   function automatic logic do_select(input logic [7:0] code, input top_s s);
      case (code)
         FC_SERVO_ON: return s.servo_on;
         FC_ZERO_SPEED: return s.zero_speed_flag;
         FC_TARGET_SPEED: return s.target_speed_reached;
         FC_POS_WINDOW: return s.position_window_reached;
         FC_TRQ_LIMITED: return s.torque_limited_flag;
         FC_FAULT_ALARM: return s.alarm;
         FC_BRAKE: return s.brake;
         FC_OL_WARNING: return s.overload_warning_out;
         FC_WARNING: return s.warn;
         default: return 1'b0;
      endcase
   endfunction

   brake_sequencer u_brake (
      .clk_in(CORE_CLK_IN),
      .srst_in(SRST_IN),
      .tick_in(st_reg.tick),
      .servo_on_in(st_reg.servo_on),
      .zero_speed_in(st_reg.zero_speed_flag),
      .on_delay_in(st_reg.bon),
      .off_delay_in(st_reg.boff),
      .brake_out(brk_raw)
   );

   overload_monitor u_overload (
      .clk_in(CORE_CLK_IN),
      .srst_in(SRST_IN),
      .tick_in(st_reg.tick),
      .overload_in(OVERLOAD_IN),
      .clear_in(st_reg.ol_clear),
      .permit_ms_in(st_reg.perm),
      .percent_in(st_reg.pct),
      .warn_out(ol_warn_raw),
      .alarm_out(ol_alarm_raw)
   );

   always_comb begin
      logic [TRQ_W-1:0] lim;
      logic [31:0] rd;
      logic mapped;
      logic wr;
      logic [INT_W-1:0] ev;
      logic [INT_W-1:0] w1c;
      lim = '0;
      rd = 32'h0000_0000;
      mapped = 1'b1;
      wr = 1'b0;
      ev = '0;
      w1c = '0;
      st_next = st_reg;

      // time base for overload and brake delays
      st_next.tick = 1'b0;
      if (st_reg.tick_cnt >= TICK_LAST) begin
         st_next.tick_cnt = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.tick_cnt = st_reg.tick_cnt + TW'(1);
      end

      // power pin crossing: change accepted once stages two and three agree
      st_next.pwr_sync = {st_reg.pwr_sync[1:0], CTRL_POWER_IN};
      if (st_reg.pwr_sync[1] == st_reg.pwr_sync[2]) begin
         st_next.servo_on = st_reg.pwr_sync[2];
      end

      st_next.target_speed_reached = SPEED_IN >= st_reg.tgt;
      st_next.zero_speed_flag = SPEED_IN <= st_reg.zero;
      st_next.position_window_reached = (st_reg.mode == MODE_PULSE_POSITION) && (POS_ERR_IN <= st_reg.win);
      lim = st_reg.ext_lim ? EXT_TRQ_LIMIT_IN : st_reg.tlim;
      st_next.torque_limited_flag = (st_reg.mode != MODE_TORQUE) && (st_reg.mode != MODE_TORQUE_INTERNAL)
         && (TORQUE_IN >= lim);
      // warning-class faults never reach the alarm line directly
      st_next.alarm = FAULT_IN || ol_alarm_raw;
      st_next.warn = |WARN_COND_IN;
      st_next.acode = ol_alarm_raw ? OL_ALARM_CODE : NO_ALARM_CODE;
      st_next.overload_warning_out = ol_warn_raw;
      st_next.brake = brk_raw;
      st_next.dout = {do_select(st_reg.sel1, st_reg), do_select(st_reg.sel0, st_reg)};

      // apb: answer prepared in setup, zero wait states in access
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.ol_clear = 1'b0;
      case (PADDR_IN)
         OFS_CTRL: rd = {28'h0, st_reg.ext_lim, st_reg.mode};
         OFS_TGT_SPEED: rd = 32'(st_reg.tgt);
         OFS_ZERO_SPEED: rd = 32'(st_reg.zero);
         OFS_POS_WINDOW: rd = 32'(st_reg.win);
         OFS_TRQ_LIMIT: rd = 32'(st_reg.tlim);
         OFS_BRAKE_ON: rd = {16'h0000, st_reg.bon};
         OFS_BRAKE_OFF: rd = {16'h0000, st_reg.boff};
         OFS_OL_PERCENT: rd = {24'h000000, st_reg.pct};
         OFS_OL_PERMIT: rd = {16'h0000, st_reg.perm};
         OFS_DO_SELECT: rd = {16'h0000, st_reg.sel1, st_reg.sel0};
         OFS_STATUS: rd = {8'h00, st_reg.acode, 7'h00, st_reg.servo_on, st_reg.zero_speed_flag,
            st_reg.brake, st_reg.overload_warning_out, st_reg.warn, st_reg.alarm, st_reg.torque_limited_flag,
            st_reg.position_window_reached, st_reg.target_speed_reached};
         OFS_INT_STATUS: rd = 32'(st_reg.ist);
         OFS_INT_MASK: rd = 32'(st_reg.imask);
         default: mapped = 1'b0;
      endcase
      if (PSEL_IN && !PENABLE_IN) begin
         st_next.pready = 1'b1;
         st_next.pslverr = !mapped;
         st_next.prdata = (mapped && !PWRITE_IN) ? rd : 32'h0000_0000;
      end
      wr = PSEL_IN && PENABLE_IN && st_reg.pready && PWRITE_IN && mapped;
      if (wr) begin
         case (PADDR_IN)
            OFS_CTRL: begin
               st_next.mode = PWDATA_IN[CTRL_MODE_LSB +: 3];
               st_next.ext_lim = PWDATA_IN[CTRL_EXT_LIM_BIT];
               st_next.ol_clear = PWDATA_IN[CTRL_ALARM_CLR_BIT];
            end
            OFS_TGT_SPEED: st_next.tgt = PWDATA_IN[SPD_W-1:0];
            OFS_ZERO_SPEED: st_next.zero = PWDATA_IN[SPD_W-1:0];
            OFS_POS_WINDOW: st_next.win = PWDATA_IN[POS_W-1:0];
            OFS_TRQ_LIMIT: st_next.tlim = PWDATA_IN[TRQ_W-1:0];
            OFS_BRAKE_ON: st_next.bon = PWDATA_IN[15:0];
            OFS_BRAKE_OFF: st_next.boff = PWDATA_IN[15:0];
            OFS_OL_PERCENT: st_next.pct = PWDATA_IN[7:0];
            OFS_OL_PERMIT: st_next.perm = PWDATA_IN[15:0];
            OFS_DO_SELECT: st_next.sel0 = PWDATA_IN[7:0];
            OFS_INT_STATUS: w1c = PWDATA_IN[INT_W-1:0];
            OFS_INT_MASK: st_next.imask = PWDATA_IN[INT_W-1:0];
            default: w1c = '0;
         endcase
         if (PADDR_IN == OFS_DO_SELECT) begin
            st_next.sel1 = PWDATA_IN[15:8];
         end
      end

      // rising edges are events, brake changes in either direction; a set in the clearing cycle survives
      ev[INT_TGT] = st_next.target_speed_reached && !st_reg.target_speed_reached;
      ev[INT_POS] = st_next.position_window_reached && !st_reg.position_window_reached;
      ev[INT_TQL] = st_next.torque_limited_flag && !st_reg.torque_limited_flag;
      ev[INT_ALARM] = st_next.alarm && !st_reg.alarm;
      ev[INT_WARN] = st_next.warn && !st_reg.warn;
      ev[INT_OLW] = st_next.overload_warning_out && !st_reg.overload_warning_out;
      ev[INT_BRAKE] = st_next.brake != st_reg.brake;
      st_next.ist = (st_reg.ist & ~w1c) | ev;
      st_next.irq = |(st_reg.ist & st_reg.imask);
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (SRST_IN) begin
         st_reg <= '0;
         st_reg.tgt <= RST_TGT_SPEED[SPD_W-1:0];
         st_reg.zero <= RST_ZERO_SPEED[SPD_W-1:0];
         st_reg.win <= RST_POS_WINDOW[POS_W-1:0];
         st_reg.tlim <= RST_TRQ_LIMIT[TRQ_W-1:0];
         st_reg.bon <= RST_BRAKE_ON;
         st_reg.boff <= RST_BRAKE_OFF;
         st_reg.pct <= RST_OL_PERCENT;
         st_reg.perm <= RST_OL_PERMIT;
         st_reg.sel0 <= RST_DO_SELECT;
      end else begin
         st_reg <= st_next;
      end
   end

   assign PRDATA_OUT = st_reg.prdata;
   assign PREADY_OUT = st_reg.pready;
   assign PSLVERR_OUT = st_reg.pslverr;
   assign TARGET_SPEED_REACHED_OUT = st_reg.target_speed_reached;
   assign POSITION_WINDOW_REACHED_OUT = st_reg.position_window_reached;
   assign TORQUE_LIMITED_FLAG_OUT = st_reg.torque_limited_flag;
   assign FAULT_ALARM_OUT = st_reg.alarm;
   assign BRAKE_CONTROL_OUT = st_reg.brake;
   assign OVERLOAD_WARNING_OUT = st_reg.overload_warning_out;
   assign ZERO_SPEED_FLAG_OUT = st_reg.zero_speed_flag;
   assign SERVO_ON_STATE_OUT = st_reg.servo_on;
   assign WARNING_OUT = st_reg.warn;
   assign ALARM_CODE_OUT = st_reg.acode;
   assign DO_OUT = st_reg.dout;
   assign IRQ_OUT = st_reg.irq;

   a_target_speed_set: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
      (SPEED_IN >= st_reg.tgt) |=> TARGET_SPEED_REACHED_OUT)
      else $error("target speed flag not set");
   a_target_speed_drop: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
      (TARGET_SPEED_REACHED_OUT && SPEED_IN < st_reg.tgt) |=> !TARGET_SPEED_REACHED_OUT)
      else $error("target speed flag not cleared");
   a_pos_mode_only: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
      (st_reg.mode != MODE_PULSE_POSITION || POS_ERR_IN > st_reg.win)
      |=> !POSITION_WINDOW_REACHED_OUT)
      else $error("position flag outside pulse mode or window");
   a_torque_mode_block: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
      (st_reg.mode == MODE_TORQUE || st_reg.mode == MODE_TORQUE_INTERNAL)
      |=> !TORQUE_LIMITED_FLAG_OUT)
      else $error("torque limited flag in torque mode");
   a_fault_alarm_on: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
      FAULT_IN |=> FAULT_ALARM_OUT)
      else $error("fault alarm not raised");
   a_warn_not_alarm: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
      ((|WARN_COND_IN) && !FAULT_IN && !ol_alarm_raw) |=> (WARNING_OUT && !FAULT_ALARM_OUT))
      else $error("warning class fault reached alarm");
   a_ol_alarm_code: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
      ol_alarm_raw |=> (FAULT_ALARM_OUT && ALARM_CODE_OUT == OL_ALARM_CODE))
      else $error("overload alarm not shown");
   a_zero_speed_flag: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
      (!SRST_IN && SPEED_IN <= st_reg.zero) |=> ZERO_SPEED_FLAG_OUT)
      else $error("zero speed flag missed");
   a_servo_on_power: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
      (!SRST_IN && CTRL_POWER_IN) [*4] |=> SERVO_ON_STATE_OUT)
      else $error("servo on state missed with power");
   a_irq_level: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
      (|(st_reg.ist & st_reg.imask)) |=> IRQ_OUT)
      else $error("interrupt not raised");

endmodule

// ===== rtl/servo_status_pkg.sv
package servo_status_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TGT_SPEED = 8'h04;
   localparam logic [7:0] OFS_ZERO_SPEED = 8'h08;
   localparam logic [7:0] OFS_POS_WINDOW = 8'h0C;
   localparam logic [7:0] OFS_TRQ_LIMIT = 8'h10;
   localparam logic [7:0] OFS_BRAKE_ON = 8'h14;
   localparam logic [7:0] OFS_BRAKE_OFF = 8'h18;
   localparam logic [7:0] OFS_OL_PERCENT = 8'h1C;
   localparam logic [7:0] OFS_OL_PERMIT = 8'h20;
   localparam logic [7:0] OFS_DO_SELECT = 8'h24;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   localparam logic [7:0] OFS_INT_STATUS = 8'h2C;
   localparam logic [7:0] OFS_INT_MASK = 8'h30;

   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_EXT_LIM_BIT = 3;
   localparam int CTRL_ALARM_CLR_BIT = 4;

   // status register fields
   localparam int STAT_CODE_LSB = 16;

   // reset values
   localparam logic [15:0] RST_TGT_SPEED = 16'h0BB8;
   localparam logic [15:0] RST_ZERO_SPEED = 16'h000A;
   localparam logic [23:0] RST_POS_WINDOW = 24'h000064;
   localparam logic [15:0] RST_TRQ_LIMIT = 16'h0064;
   localparam logic [15:0] RST_BRAKE_ON = 16'h0000;
   localparam logic [15:0] RST_BRAKE_OFF = 16'h0000;
   localparam logic [7:0] RST_OL_PERCENT = 8'h3C;
   localparam logic [15:0] RST_OL_PERMIT = 16'h1F40;
   localparam logic [7:0] RST_DO_SELECT = 8'h07;

   // output function codes
   localparam logic [7:0] FC_SERVO_ON = 8'h02;
   localparam logic [7:0] FC_ZERO_SPEED = 8'h03;
   localparam logic [7:0] FC_TARGET_SPEED = 8'h04;
   localparam logic [7:0] FC_POS_WINDOW = 8'h05;
   localparam logic [7:0] FC_TRQ_LIMITED = 8'h06;
   localparam logic [7:0] FC_FAULT_ALARM = 8'h07;
   localparam logic [7:0] FC_BRAKE = 8'h08;
   localparam logic [7:0] FC_OL_WARNING = 8'h10;
   localparam logic [7:0] FC_WARNING = 8'h11;

   localparam logic [7:0] OL_ALARM_CODE = 8'h06;
   localparam logic [7:0] NO_ALARM_CODE = 8'h00;
   localparam logic [31:0] PCT_FULL = 32'h0000_0064;

   // interrupt bits
   localparam int INT_W = 7;
   localparam int INT_TGT = 0;
   localparam int INT_POS = 1;
   localparam int INT_TQL = 2;
   localparam int INT_ALARM = 3;
   localparam int INT_WARN = 4;
   localparam int INT_OLW = 5;
   localparam int INT_BRAKE = 6;

   // time base: overload and brake delays counted in milliseconds
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_TIME_NS = 1000000;
   localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      MODE_PULSE_POSITION = 3'h0,
      MODE_REG_POSITION = 3'h1,
      MODE_SPEED = 3'h2,
      MODE_TORQUE = 3'h3,
      MODE_SPEED_INTERNAL = 3'h4,
      MODE_TORQUE_INTERNAL = 3'h5
   } ctrl_mode_e;

   typedef enum logic [3:0] {
      BRK_RELEASED = 4'h1,
      BRK_ON_WAIT = 4'h2,
      BRK_ACTIVE = 4'h4,
      BRK_OFF_WAIT = 4'h8
   } brake_state_e;

endpackage

// ===== rtl/brake_sequencer.sv
`timescale 1ns/1ps
module brake_sequencer import servo_status_pkg::*; (
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // timing and conditions
   input wire logic tick_in,
   input wire logic servo_on_in,
   input wire logic zero_speed_in,
   input wire logic [15:0] on_delay_in,
   input wire logic [15:0] off_delay_in,
   // brake drive
   output logic brake_out
);

   typedef struct packed {
      brake_state_e state;
      logic [15:0] cnt;
      logic brake;
   } brk_s;

   brk_s st_reg;
   brk_s st_next;

   always_comb begin
      st_next = st_reg;
      if (tick_in && st_reg.cnt != 16'hFFFF) begin
         st_next.cnt = st_reg.cnt + 16'h0001;
      end
      case (st_reg.state)
         BRK_RELEASED: begin
            if (servo_on_in) begin
               st_next.state = BRK_ON_WAIT;
               st_next.cnt = 16'h0000;
            end
         end
         BRK_ON_WAIT: begin
            if (!servo_on_in) begin
               st_next.state = BRK_RELEASED;
            end else if (st_reg.cnt >= on_delay_in) begin
               st_next.state = BRK_ACTIVE;
            end
         end
         BRK_ACTIVE: begin
            if (!servo_on_in) begin
               st_next.state = BRK_OFF_WAIT;
               st_next.cnt = 16'h0000;
            end
         end
         BRK_OFF_WAIT: begin
            if (servo_on_in) begin
               st_next.state = BRK_ACTIVE;
            end else if (st_reg.cnt >= off_delay_in || zero_speed_in) begin
               st_next.state = BRK_RELEASED;
            end
         end
         default: begin
            st_next.state = BRK_RELEASED;
         end
      endcase
      // output follows the state it leaves for, so it lags only one flop
      st_next.brake = (st_next.state == BRK_ACTIVE) || (st_next.state == BRK_OFF_WAIT);
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st_reg <= '{state: BRK_RELEASED, cnt: 16'h0000, brake: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign brake_out = st_reg.brake;

   a_brake_off_power: assert property (@(posedge clk_in) disable iff (srst_in)
      (st_reg.state == BRK_RELEASED && !servo_on_in) |=> !brake_out)
      else $error("brake active without servo on");
   a_brake_zero_rel: assert property (@(posedge clk_in) disable iff (srst_in)
      (st_reg.state == BRK_OFF_WAIT && !servo_on_in && zero_speed_in) |=> !brake_out)
      else $error("brake not released at zero speed");

endmodule

// ===== rtl/overload_monitor.sv
`timescale 1ns/1ps
module overload_monitor import servo_status_pkg::*; (
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // load condition and settings
   input wire logic tick_in,
   input wire logic overload_in,
   input wire logic clear_in,
   input wire logic [15:0] permit_ms_in,
   input wire logic [7:0] percent_in,
   // results
   output logic warn_out,
   output logic alarm_out
);

   typedef struct packed {
      logic [15:0] cnt;
      logic warn;
      logic alarm;
   } ol_s;

   ol_s st_reg;
   ol_s st_next;
   logic [15:0] warn_limit;

   function automatic logic [15:0] scale_pct(input logic [15:0] t, input logic [7:0] p);
      logic [31:0] prod;
      prod = 32'(t) * 32'(p);
      return 16'(prod / PCT_FULL);
   endfunction

   assign warn_limit = scale_pct(permit_ms_in, percent_in);

   always_comb begin
      st_next = st_reg;
      // only an unbroken overload accumulates
      if (!overload_in) begin
         st_next.cnt = 16'h0000;
      end else if (tick_in && st_reg.cnt != 16'hFFFF) begin
         st_next.cnt = st_reg.cnt + 16'h0001;
      end
      st_next.warn = st_reg.cnt > warn_limit;
      if (st_reg.cnt > permit_ms_in) begin
         st_next.alarm = 1'b1;
      end else if (clear_in) begin
         st_next.alarm = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st_reg <= '{cnt: 16'h0000, warn: 1'b0, alarm: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign warn_out = st_reg.warn;
   assign alarm_out = st_reg.alarm;

   a_ol_warn_time: assert property (@(posedge clk_in) disable iff (srst_in)
      (st_reg.cnt > warn_limit) |=> warn_out)
      else $error("overload warning missed");
   a_ol_alarm_latch: assert property (@(posedge clk_in) disable iff (srst_in)
      (st_reg.cnt > permit_ms_in) |=> alarm_out ##1 (alarm_out || $past(clear_in)))
      else $error("overload alarm not held");

endmodule

// ===== test/status_reader.sv
`timescale 1ns/1ps
module status_reader (
   // clock
   input wire logic clk_in,
   // drive pins seen by the controller
   input wire logic [1:0] do_in,
   input wire logic irq_in,
   // controller's latched view
   output logic [1:0] do_seen_out,
   output logic irq_seen_out
);
   // input stage samples once per edge, like a scan cycle, so it adds one cycle
   always_ff @(posedge clk_in) begin
      do_seen_out <= do_in;
      irq_seen_out <= irq_in;
   end
endmodule

// ===== test/servo_status_output_tb.sv
`timescale 1ns/1ps
module servo_status_output_tb import servo_status_pkg::*; ;
   typedef struct packed {logic sts; logic err; logic [31:0] msk; logic [31:0] exp;} note_s;
   note_s q[$];
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pwr_in = 1, flt = 0, ovl = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [15:0] spd = 0, trq = 0, ext = 0, tgt;
   logic [23:0] perr = 0;
   logic [4:0] wc = 0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, irq_seen;
   logic [1:0] dout, do_seen;
   wire [8:0] flg;
   wire [7:0] acode;
   int n_fail = 0, n_compared = 0;
   always #2.5 clk = ~clk;
   servo_status_output #(.TICK_DIV(4)) u_servo_status_output (
      .CORE_CLK_IN(clk), .SRST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .CTRL_POWER_IN(pwr_in), .SPEED_IN(spd), .POS_ERR_IN(perr),
      .TORQUE_IN(trq), .EXT_TRQ_LIMIT_IN(ext), .FAULT_IN(flt), .WARN_COND_IN(wc),
      .OVERLOAD_IN(ovl), .TARGET_SPEED_REACHED_OUT(flg[0]),
      .POSITION_WINDOW_REACHED_OUT(flg[1]), .TORQUE_LIMITED_FLAG_OUT(flg[2]),
      .FAULT_ALARM_OUT(flg[3]), .WARNING_OUT(flg[4]), .OVERLOAD_WARNING_OUT(flg[5]),
      .BRAKE_CONTROL_OUT(flg[6]), .ZERO_SPEED_FLAG_OUT(flg[7]), .SERVO_ON_STATE_OUT(flg[8]),
      .ALARM_CODE_OUT(acode), .DO_OUT(dout), .IRQ_OUT(irq));
   status_reader u_status_reader (.clk_in(clk), .do_in(dout), .irq_in(irq),
      .do_seen_out(do_seen), .irq_seen_out(irq_seen));
   task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task print_verdict;
      if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1;
      // pready read at the edge itself, before the design's update lands
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (pready !== 1'b1) n_fail++;
      psel <= 0;
      pen <= 0;
      // one idle edge so the next call never re-drives psel in this step
      @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
           input logic r = 1'b0);
      q.push_back({(a == OFS_STATUS), r, m, e});
      apb(1'b0, a, 32'h0);
   endtask
   task st(input int b, input logic v);
      rd(OFS_STATUS, 32'(v) << b, 32'h1 << b);
   endtask
   // read data taken only at the edge that samples pready high
   always @(posedge clk) begin
      note_s n;
      if (psel && pen && pready === 1'b1 && !pwr && q.size() > 0) begin
         n = q.pop_front();
         chk("prdata", {pslverr, prdata & n.msk}, {n.err, n.exp});
         // status pins must agree with the expected status word
         if (n.sts) chk("pins", {9'h000, acode, 7'h00, flg} & 33'(n.msk), 33'(n.exp));
      end
   end
   initial begin
      #(5 * 20000);
      n_fail++;
      print_verdict;
   end
   initial begin
      void'($urandom(32'h90B9));
      tgt = 16'(32'h14 + $urandom % 32'h384);
      cyc(20);
      rst <= 0;
      cyc(12);
      rd(OFS_TGT_SPEED, 32'h0BB8);
      rd(OFS_OL_PERMIT, 32'h1F40);
      rd(OFS_DO_SELECT, 32'h0007);
      rd(8'h40, 32'h0, 32'hFFFFFFFF, 1'b1);
      st(8, 1);
      st(7, 1);
      st(6, 1);
      spd <= 16'h000A; cyc(3); st(7, 1);
      spd <= 16'h000B; cyc(3); st(7, 0);
      wr(OFS_TGT_SPEED, 32'(tgt));
      spd <= tgt - 16'h1; cyc(3); st(0, 0);
      spd <= tgt; cyc(3); st(0, 1);
      spd <= tgt + 16'h1; cyc(3); st(0, 1);
      spd <= tgt - 16'h1; cyc(3); st(0, 0);
      perr <= 24'h64; cyc(3); st(1, 1);
      perr <= 24'h65; cyc(3); st(1, 0);
      perr <= 24'h64; wr(OFS_CTRL, 32'h1); cyc(3); st(1, 0);
      trq <= 16'h64;
      for (int m = 0; m < 6; m++) begin
         wr(OFS_CTRL, 32'(m)); cyc(3); st(2, m != 3 && m != 5);
      end
      ext <= 16'hC8; wr(OFS_CTRL, 32'h8); cyc(3); st(2, 0);
      trq <= 16'hC8; cyc(3); st(2, 1);
      trq <= 0; flt <= 1;
      for (int m = 0; m < 6; m++) begin
         wr(OFS_CTRL, 32'(m)); cyc(3); st(3, 1);
      end
      chk("do_out", 33'(do_seen), 33'h1);
      flt <= 0; wr(OFS_CTRL, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wc <= 5'h1 << i; cyc(3); rd(OFS_STATUS, 32'h10, 32'h18);
      end
      wc <= 0; wr(OFS_INT_MASK, 32'h10); wr(OFS_INT_STATUS, 32'h7F); cyc(3);
      chk("irq", 33'(irq_seen), 33'h0);
      wc <= 5'h1; cyc(4); chk("irq", 33'(irq_seen), 33'h1);
      wr(OFS_INT_MASK, 32'h0); cyc(3); chk("irq", 33'(irq_seen), 33'h0);
      wr(OFS_INT_MASK, 32'h10); cyc(3); chk("irq", 33'(irq_seen), 33'h1);
      wr(OFS_INT_STATUS, 32'h10); cyc(3); chk("irq", 33'(irq_seen), 33'h0);
      wc <= 0; wr(OFS_OL_PERMIT, 32'hA); wr(OFS_OL_PERCENT, 32'h32);
      ovl <= 1; cyc(14); st(5, 0);
      cyc(16); rd(OFS_STATUS, 32'h20, 32'h28);
      cyc(24); rd(OFS_STATUS, 32'h0006_0028, 32'h00FF_0028);
      wr(OFS_DO_SELECT, {16'h0000, FC_OL_WARNING, FC_TRQ_LIMITED}); cyc(3);
      chk("do_out", 33'(do_seen), 33'h2);
      wr(OFS_DO_SELECT, {16'h0000, FC_TARGET_SPEED, FC_BRAKE}); cyc(3);
      chk("do_out", 33'(do_seen), 33'h1);
      wr(OFS_DO_SELECT, {16'h0000, FC_POS_WINDOW, FC_SERVO_ON}); cyc(3);
      chk("do_out", 33'(do_seen), 33'h3);
      wr(OFS_DO_SELECT, {16'h0000, FC_WARNING, FC_FAULT_ALARM}); cyc(3);
      chk("do_out", 33'(do_seen), 33'h1);
      ovl <= 0; cyc(2); wr(OFS_CTRL, 32'h10); cyc(3);
      rd(OFS_STATUS, 32'h0, 32'h00FF_0028);
      spd <= 16'h64; wr(OFS_BRAKE_OFF, 32'h3); pwr_in <= 0; cyc(6); st(6, 1);
      cyc(30); st(6, 0);
      wr(OFS_BRAKE_ON, 32'h5); pwr_in <= 1; cyc(10); st(6, 0);
      cyc(30); st(6, 1);
      wr(OFS_BRAKE_OFF, 32'hFFF); spd <= 0; pwr_in <= 0; cyc(16); st(6, 0);
      cyc(5);
      print_verdict;
   end
endmodule
